// ### hw/snoop_map.svh
// Constants shared by both ends of the coherent snoop link.
// Assumes a single bus clock; included by bare name.
`ifndef SNOOP_MAP_SVH
`define SNOOP_MAP_SVH

// ----------------------------------------
// Line geometry
// ----------------------------------------
`define LINE_WORDS 4
`define WORD_OFS_W 2

// ----------------------------------------
// Timing counts, in bus cycles after address_strobe, and their field width
// ----------------------------------------
`define STD_SNOOP_CYC 2
`define LAT_W 4
`define RESET_MIN_RD_LAT 4'h2
`define RESET_INV_DELAY 4'h2
`define PLAIN_ACK_CYC 4'h2

// ----------------------------------------
// Reset values of configuration state
// ----------------------------------------
`define RESET_REFLECT_EN 1'b0

`endif

// ### hw/snoop_pkg.sv
// Types and helpers shared by the memory end and the cache end.
// Assumes snoop_map.svh is on the include path.
`include "snoop_map.svh"

package snoop_pkg;

  typedef enum logic [2:0] {
    TXN_READ,
    TXN_WRITE,
    TXN_COH_READ,
    TXN_COH_READ_INV,
    TXN_COH_INV,
    TXN_COH_WRITE_INV
  } txn_t;

  typedef logic [`WORD_OFS_W-1:0] word_ofs_t;
  typedef logic [`LAT_W-1:0] lat_t;

  function automatic logic is_coh_read(input txn_t t);
    return (t == TXN_COH_READ) || (t == TXN_COH_READ_INV);
  endfunction

  function automatic logic is_write(input txn_t t);
    return (t == TXN_WRITE) || (t == TXN_COH_WRITE_INV);
  endfunction

  // Wrapped burst: starts at the given word and wraps within the line
  function automatic word_ofs_t wrap_idx(input word_ofs_t start,
                                         input word_ofs_t beat);
    return word_ofs_t'(start + beat);
  endfunction

  // Never earlier than the standard snoop point
  function automatic lat_t at_least_std(input lat_t v);
    return (v < lat_t'(`STD_SNOOP_CYC)) ? lat_t'(`STD_SNOOP_CYC) : v;
  endfunction

endpackage

// ### hw/snoop_link_if.sv
// Point-to-point model of the shared coherent bus between memory
// and the caching modules. No tristate: each wire has one driver.
`timescale 1ns/1ps
`default_nettype none

interface snoop_link_if
  import snoop_pkg::*;
#(
  parameter int AW = 4,
  parameter int DW = 32
);
  logic address_strobe;
  txn_t txn_type;
  logic [AW-1:0] line_addr;
  word_ofs_t word_offset;
  logic [DW-1:0] muxed_address_data;
  logic cache_data_valid;
  logic intervention_inhibit;
  logic shared_line_flag;
  logic [DW-1:0] read_data;
  logic data_ready_ack;
  logic relinquish_and_retry;

  modport memory (
    input address_strobe, txn_type, line_addr, word_offset,
    input muxed_address_data, cache_data_valid,
    input intervention_inhibit, shared_line_flag,
    output read_data, data_ready_ack, relinquish_and_retry
  );

  modport cache (
    output address_strobe, txn_type, line_addr, word_offset,
    output muxed_address_data, cache_data_valid,
    output intervention_inhibit, shared_line_flag,
    input read_data, data_ready_ack, relinquish_and_retry
  );
endinterface

`default_nettype wire

// ### hw/cache_end.sv
// Caching-module end: issues transactions and snoops coherent reads.
// Assumes the memory end shares clk and honours its latency settings.
`timescale 1ns/1ps
`default_nettype none

module cache_end
  import snoop_pkg::*;
#(
  parameter int AW = 4,
  parameter int DW = 32,
  parameter int SNOOP_LAT = `STD_SNOOP_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  snoop_link_if.cache link,
  input wire logic cmd_valid,
  input wire txn_t cmd_type,
  input wire logic [AW-1:0] cmd_addr,
  input wire word_ofs_t cmd_offset,
  input wire logic [DW-1:0] cmd_wdata,
  output logic cmd_ready,
  input wire logic snoop_dirty,
  input wire logic snoop_shared,
  input wire logic reflect_mode,
  input wire logic [DW-1:0] line_word,
  output word_ofs_t line_word_idx,
  output logic [DW-1:0] rdata,
  output logic rdata_valid,
  output logic done,
  output logic retried,
  output logic saw_inhibit,
  output logic saw_shared,
  output logic line_clean
);

  typedef enum {C_IDLE, C_WAIT, C_SUPPLY} cstate_t;

  cstate_t st_q, st_d;
  txn_t typ_q, typ_d;
  logic [AW-1:0] addr_q, addr_d;
  word_ofs_t off_q, off_d, beat_q, beat_d, idx_q, idx_d;
  lat_t cnt_q, cnt_d;
  logic strobe_q, strobe_d, dval_q, dval_d, inh_q, inh_d, shr_q, shr_d;
  logic [DW-1:0] dat_q, dat_d, rdata_q, rdata_d;
  logic rv_q, rv_d, done_q, done_d, rr_q, rr_d;
  logic sinh_q, sinh_d, sshr_q, sshr_d, clean_q, clean_d, ack_seen_q;
  logic ack_seen_d, dirty_q, dirty_d, rdy_q, rdy_d;

  always_comb begin
    st_d = st_q;
    typ_d = typ_q;
    addr_d = addr_q;
    off_d = off_q;
    beat_d = beat_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    strobe_d = 1'b0;
    dval_d = 1'b0;
    inh_d = 1'b0;
    shr_d = 1'b0;
    dat_d = dat_q;
    rdata_d = rdata_q;
    rv_d = 1'b0;
    done_d = 1'b0;
    rr_d = 1'b0;
    sinh_d = sinh_q;
    sshr_d = sshr_q;
    clean_d = 1'b0;
    ack_seen_d = ack_seen_q;
    dirty_d = dirty_q;
    unique case (st_q)
      C_IDLE: begin
        if (cmd_valid) begin
          typ_d = cmd_type;
          addr_d = cmd_addr;
          off_d = cmd_offset;
          strobe_d = 1'b1;
          cnt_d = '0;
          beat_d = '0;
          sinh_d = 1'b0;
          sshr_d = 1'b0;
          ack_seen_d = 1'b0;
          dirty_d = snoop_dirty && is_coh_read(cmd_type);
          st_d = C_WAIT;
        end
      end
      C_WAIT: begin
        if (cnt_q != '1) begin
          cnt_d = lat_t'(cnt_q + 1'b1);
        end
        // Write data goes out on the cycle after the strobe
        if (cnt_q == '0 && is_write(typ_q)) begin
          dval_d = 1'b1;
          dat_d = cmd_wdata;
        end
        // One-cycle joint response at the snoop point
        if (is_coh_read(typ_q) && cnt_q == lat_t'(SNOOP_LAT - 1)) begin
          inh_d = dirty_q;
          shr_d = snoop_shared || dirty_q;
        end
        // Observe the pair from A+2 until the first ack
        if (cnt_q >= lat_t'(`STD_SNOOP_CYC) && !ack_seen_q) begin
          sinh_d = sinh_q || link.intervention_inhibit;
          sshr_d = sshr_q || link.shared_line_flag;
        end
        if (link.relinquish_and_retry) begin
          rr_d = 1'b1;
          done_d = 1'b1;
          st_d = C_IDLE;
        end else if (link.data_ready_ack) begin
          ack_seen_d = 1'b1;
          rdata_d = link.read_data;
          rv_d = !is_write(typ_q) && (typ_q != TXN_COH_INV);
          beat_d = word_ofs_t'(beat_q + 1'b1);
          if (typ_q == TXN_COH_INV || is_write(typ_q) ||
              beat_q == word_ofs_t'(`LINE_WORDS - 1)) begin
            done_d = 1'b1;
            st_d = C_IDLE;
          end
        end else if (inh_q) begin
          beat_d = '0;
          idx_d = off_q;
          st_d = C_SUPPLY;
        end
      end
      C_SUPPLY: begin
        // Wrapped line delivery from the intervening cache
        dval_d = 1'b1;
        dat_d = line_word;
        rdata_d = line_word;
        rv_d = 1'b1;
        beat_d = word_ofs_t'(beat_q + 1'b1);
        idx_d = wrap_idx(off_q, word_ofs_t'(beat_q + 1'b1));
        if (beat_q == word_ofs_t'(`LINE_WORDS - 1)) begin
          clean_d = reflect_mode;
          done_d = 1'b1;
          st_d = C_IDLE;
        end
      end
      default: st_d = C_IDLE;
    endcase
    // Registered so the ready port comes straight from a flop
    rdy_d = (st_d == C_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= C_IDLE;
      typ_q <= TXN_READ;
      addr_q <= '0;
      off_q <= '0;
      beat_q <= '0;
      idx_q <= '0;
      cnt_q <= '0;
      strobe_q <= 1'b0;
      dval_q <= 1'b0;
      inh_q <= 1'b0;
      shr_q <= 1'b0;
      dat_q <= '0;
      rdata_q <= '0;
      rv_q <= 1'b0;
      done_q <= 1'b0;
      rr_q <= 1'b0;
      sinh_q <= 1'b0;
      sshr_q <= 1'b0;
      clean_q <= 1'b0;
      ack_seen_q <= 1'b0;
      dirty_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      typ_q <= typ_d;
      addr_q <= addr_d;
      off_q <= off_d;
      beat_q <= beat_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      strobe_q <= strobe_d;
      dval_q <= dval_d;
      inh_q <= inh_d;
      shr_q <= shr_d;
      dat_q <= dat_d;
      rdata_q <= rdata_d;
      rv_q <= rv_d;
      done_q <= done_d;
      rr_q <= rr_d;
      sinh_q <= sinh_d;
      sshr_q <= sshr_d;
      clean_q <= clean_d;
      ack_seen_q <= ack_seen_d;
      dirty_q <= dirty_d;
      rdy_q <= rdy_d;
    end
  end

  assign link.address_strobe = strobe_q;
  assign link.txn_type = typ_q;
  assign link.line_addr = addr_q;
  assign link.word_offset = off_q;
  assign link.muxed_address_data = dat_q;
  assign link.cache_data_valid = dval_q;
  assign link.intervention_inhibit = inh_q;
  assign link.shared_line_flag = shr_q;
  assign cmd_ready = rdy_q;
  assign line_word_idx = idx_q;
  assign rdata = rdata_q;
  assign rdata_valid = rv_q;
  assign done = done_q;
  assign retried = rr_q;
  assign saw_inhibit = sinh_q;
  assign saw_shared = sshr_q;
  assign line_clean = clean_q;

endmodule // cache_end

`default_nettype wire

// ### hw/mem_ctrl_end.sv
// Memory-controller end of the coherent link, with line-ownership
// hold for retried lines and an invalidate forwarding queue.
// Assumes the cache end shares clk; config inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_end
  import snoop_pkg::*;
#(
  parameter int AW = 4,
  parameter int DW = 32,
  parameter int QDEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  snoop_link_if.memory link,
  input wire logic reflect_en,
  input wire logic ack_src_en,
  input wire lat_t min_rd_lat,
  input wire lat_t inv_delay,
  input wire logic rr_issue,
  input wire logic rr_resolve,
  output logic rr_outstanding,
  output logic aborted,
  output logic inv_fwd_valid,
  output logic [AW-1:0] inv_fwd_addr,
  input wire logic inv_fwd_ready
);

  localparam int MW = AW + `WORD_OFS_W;
  localparam int QW = $clog2(QDEPTH);

  typedef enum {M_IDLE, M_WAIT, M_BURST, M_REFLECT} mstate_t;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [DW-1:0] mem [2**MW];
  logic [DW-1:0] rq_data [QDEPTH];
  logic [MW-1:0] rq_loc [QDEPTH];
  logic [AW-1:0] iq_addr [QDEPTH];

  mstate_t st_q, st_d;
  txn_t typ_q, typ_d;
  logic [AW-1:0] addr_q, addr_d, hold_addr_q, hold_addr_d;
  word_ofs_t off_q, off_d, beat_q, beat_d;
  lat_t cnt_q, cnt_d, lat;
  logic [DW-1:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic ack_q, ack_d, rr_q, rr_d, abort_q, abort_d;
  logic hold_q, hold_d, rr_pend_q, rr_pend_d, refl_q, refl_d;
  logic mem_we;
  logic [MW-1:0] mem_wa;
  logic [DW-1:0] mem_wd;
  logic rq_push, rq_pop, iq_push, iq_pop, fv_q, fv_d;
  logic [AW-1:0] fa_q, fa_d;
  logic [QW:0] rq_cnt_q, rq_cnt_d, iq_cnt_q, iq_cnt_d;
  logic [QW-1:0] rq_wp_q, rq_wp_d, rq_rp_q, rq_rp_d;
  logic [QW-1:0] iq_wp_q, iq_wp_d, iq_rp_q, iq_rp_d;

  always_comb begin
    unique case (typ_q)
      TXN_COH_READ, TXN_COH_READ_INV: lat = at_least_std(min_rd_lat);
      TXN_COH_INV: lat = at_least_std(inv_delay);
      default: lat = `PLAIN_ACK_CYC;
    endcase
  end

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    typ_d = typ_q;
    addr_d = addr_q;
    off_d = off_q;
    beat_d = beat_q;
    cnt_d = cnt_q;
    rdata_d = rdata_q;
    wdata_d = wdata_q;
    ack_d = 1'b0;
    rr_d = 1'b0;
    abort_d = 1'b0;
    hold_d = hold_q && !rr_resolve;
    hold_addr_d = hold_addr_q;
    rr_pend_d = rr_pend_q;
    refl_d = refl_q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = wdata_q;
    rq_push = 1'b0;
    iq_push = 1'b0;
    unique case (st_q)
      M_IDLE: begin
        if (link.address_strobe) begin
          typ_d = link.txn_type;
          addr_d = link.line_addr;
          off_d = link.word_offset;
          cnt_d = lat_t'(1);
          beat_d = '0;
          refl_d = reflect_en;
          // Owned line, or a fresh retry, answers with a retry
          rr_pend_d = (hold_q && link.line_addr == hold_addr_q) ||
                      (rr_issue && !hold_q);
          if (rr_issue && !hold_q) begin
            hold_d = 1'b1;
            hold_addr_d = link.line_addr;
          end
          st_d = M_WAIT;
        end
      end
      M_WAIT: begin
        if (cnt_q != '1) begin
          cnt_d = lat_t'(cnt_q + 1'b1);
        end
        if (link.cache_data_valid) begin
          wdata_d = link.muxed_address_data;
        end
        if (is_coh_read(typ_q) && !rr_pend_q &&
            cnt_q >= lat_t'(`STD_SNOOP_CYC) &&
            link.intervention_inhibit) begin
          iq_push = (typ_q == TXN_COH_READ_INV);
          beat_d = '0;
          if (refl_q) begin
            st_d = M_REFLECT;
          end else begin
            abort_d = 1'b1;
            st_d = M_IDLE;
          end
        end else if (cnt_q >= lat) begin
          st_d = M_IDLE;
          rr_pend_d = 1'b0;
          if (rr_pend_q) begin
            rr_d = 1'b1;
          end else if (typ_q == TXN_COH_INV) begin
            ack_d = ack_src_en;
          end else if (is_write(typ_q)) begin
            mem_we = 1'b1;
            mem_wa = {addr_q, off_q};
            ack_d = 1'b1;
          end else begin
            st_d = M_BURST;
          end
        end
      end
      M_BURST: begin
        ack_d = 1'b1;
        rdata_d = mem[{addr_q, wrap_idx(off_q, beat_q)}];
        beat_d = word_ofs_t'(beat_q + 1'b1);
        if (beat_q == word_ofs_t'(`LINE_WORDS - 1)) begin
          st_d = M_IDLE;
        end
      end
      M_REFLECT: begin
        if (link.cache_data_valid) begin
          rq_push = 1'b1;
          beat_d = word_ofs_t'(beat_q + 1'b1);
          if (beat_q == word_ofs_t'(`LINE_WORDS - 1)) begin
            st_d = M_IDLE;
          end
        end
      end
      default: st_d = M_IDLE;
    endcase
    // Reflected data drains whenever the array port is free
    rq_pop = (rq_cnt_q != '0) && !mem_we;
    if (rq_pop) begin
      mem_we = 1'b1;
      mem_wa = rq_loc[rq_rp_q];
      mem_wd = rq_data[rq_rp_q];
    end
  end

  // ----------------------------------------
  // Queue pointers
  // ----------------------------------------
  always_comb begin
    // A full reflect queue would lose data; QDEPTH must cover bursts
    rq_wp_d = rq_push ? QW'(rq_wp_q + 1'b1) : rq_wp_q;
    rq_rp_d = rq_pop ? QW'(rq_rp_q + 1'b1) : rq_rp_q;
    rq_cnt_d = (QW + 1)'(rq_cnt_q + rq_push - rq_pop);
    iq_pop = (iq_cnt_q != '0) && (!fv_q || inv_fwd_ready);
    fv_d = iq_pop || (fv_q && !inv_fwd_ready);
    fa_d = iq_pop ? iq_addr[iq_rp_q] : fa_q;
    iq_wp_d = iq_push ? QW'(iq_wp_q + 1'b1) : iq_wp_q;
    iq_rp_d = iq_pop ? QW'(iq_rp_q + 1'b1) : iq_rp_q;
    iq_cnt_d = (QW + 1)'(iq_cnt_q + iq_push - iq_pop);
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (rq_push) begin
      rq_data[rq_wp_q] <= link.muxed_address_data;
      rq_loc[rq_wp_q] <= {addr_q, wrap_idx(off_q, beat_q)};
    end
    if (iq_push) begin
      iq_addr[iq_wp_q] <= addr_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= M_IDLE;
      typ_q <= TXN_READ;
      addr_q <= '0;
      off_q <= '0;
      beat_q <= '0;
      cnt_q <= '0;
      rdata_q <= '0;
      wdata_q <= '0;
      ack_q <= 1'b0;
      rr_q <= 1'b0;
      abort_q <= 1'b0;
      hold_q <= 1'b0;
      hold_addr_q <= '0;
      rr_pend_q <= 1'b0;
      refl_q <= `RESET_REFLECT_EN;
      rq_cnt_q <= '0;
      rq_wp_q <= '0;
      rq_rp_q <= '0;
      iq_cnt_q <= '0;
      iq_wp_q <= '0;
      iq_rp_q <= '0;
      fv_q <= 1'b0;
      fa_q <= '0;
    end else begin
      st_q <= st_d;
      typ_q <= typ_d;
      addr_q <= addr_d;
      off_q <= off_d;
      beat_q <= beat_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      wdata_q <= wdata_d;
      ack_q <= ack_d;
      rr_q <= rr_d;
      abort_q <= abort_d;
      hold_q <= hold_d;
      hold_addr_q <= hold_addr_d;
      rr_pend_q <= rr_pend_d;
      refl_q <= refl_d;
      rq_cnt_q <= rq_cnt_d;
      rq_wp_q <= rq_wp_d;
      rq_rp_q <= rq_rp_d;
      iq_cnt_q <= iq_cnt_d;
      iq_wp_q <= iq_wp_d;
      iq_rp_q <= iq_rp_d;
      fv_q <= fv_d;
      fa_q <= fa_d;
    end
  end

  assign link.read_data = rdata_q;
  assign link.data_ready_ack = ack_q;
  assign link.relinquish_and_retry = rr_q;
  assign rr_outstanding = hold_q;
  assign aborted = abort_q;
  assign inv_fwd_valid = fv_q;
  assign inv_fwd_addr = fa_q;

endmodule // mem_ctrl_end

`default_nettype wire

// ### verification/snoop_link_assertions.sv
// Concurrent checks on the coherent snoop link between the two ends.
// Assumes it sits beside the link interface, one clock, rst_b async low.
`timescale 1ns/1ps
`default_nettype none

module snoop_link_assertions
  import snoop_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic address_strobe,
  input wire txn_t txn_type,
  input wire logic intervention_inhibit,
  input wire logic shared_line_flag,
  input wire logic data_ready_ack,
  input wire logic relinquish_and_retry
);
  // ----------------------------------------
  // Link timing
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_FLAGS_TOGETHER: assert property (
    intervention_inhibit |-> shared_line_flag)
    else $error("inhibit without shared flag");
  AST_INH_ONE_CYCLE: assert property (
    intervention_inhibit |=> !intervention_inhibit)
    else $error("inhibit longer than one cycle");
  AST_INH_AT_A2: assert property (
    intervention_inhibit |-> $past(address_strobe, 2)
      && is_coh_read(txn_type))
    else $error("inhibit not two cycles after strobe");
  AST_CR_NO_EARLY_ACK: assert property (
    address_strobe && is_coh_read(txn_type) |=> !data_ready_ack [*3])
    else $error("coherent read acked before snoop point");
  AST_CR_ANSWER_BOUND: assert property (
    address_strobe && is_coh_read(txn_type) |-> ##[2:20]
      (data_ready_ack || intervention_inhibit || relinquish_and_retry))
    else $error("coherent read never answered");
  AST_CI_ACK_LATE: assert property (
    address_strobe && txn_type == TXN_COH_INV |=> !data_ready_ack [*2])
    else $error("invalidate acked too early");
  // Bursts of different lines never touch: next strobe waits for done
  AST_BURST_FOUR: assert property (
    $rose(data_ready_ack) && is_coh_read(txn_type)
      |-> data_ready_ack [*4] ##1 !data_ready_ack)
    else $error("coherent read burst not four beats");
  AST_INH_STOPS_ACK: assert property (
    intervention_inhibit && !data_ready_ack |=> !data_ready_ack [*6])
    else $error("memory acked an intervened read");
  AST_RETRY_NO_ACK: assert property (
    relinquish_and_retry |-> !data_ready_ack
      ##1 (!data_ready_ack && !relinquish_and_retry))
    else $error("retry answer with ack or held");
endmodule // snoop_link_assertions

`default_nettype wire

// ### verification/test_coherent_snoop_response_timing.sv
// Self-checking bench: memory end and cache end joined by the link.
// Assumes snoop_pkg compiled first and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module test_coherent_snoop_response_timing
  import snoop_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b, cmd_valid, cmd_ready, snoop_dirty, snoop_shared;
  logic reflect_mode, rdata_valid, done, retried, saw_inh, saw_sh;
  logic line_clean, reflect_en, ack_src_en, rr_issue, rr_resolve;
  logic rr_out, aborted, fwd_v, fwd_rdy, g_clean, g_abort, got_rt;
  txn_t cmd_type;
  logic [3:0] cmd_addr, fwd_a;
  word_ofs_t cmd_offset, idx;
  logic [31:0] cmd_wdata, line_word, rdata;
  lat_t min_rd_lat, inv_delay;
  logic [31:0] rq[$];
  int since, ack_at, cyc, error_cnt, num_checks;

  always #5 clk = ~clk;
  // Line store of the snooping cache, answers by word index at once
  assign line_word = 32'hc0de0000 | {30'h0, idx};

  snoop_link_if snoop_link_if_inst ();
  cache_end cache_end_inst (
    .clk(clk), .rst_b(rst_b), .link(snoop_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_addr(cmd_addr),
    .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .snoop_dirty(snoop_dirty),
    .snoop_shared(snoop_shared), .reflect_mode(reflect_mode),
    .line_word(line_word), .line_word_idx(idx), .rdata(rdata),
    .rdata_valid(rdata_valid), .done(done), .retried(retried),
    .saw_inhibit(saw_inh), .saw_shared(saw_sh),
    .line_clean(line_clean));
  mem_ctrl_end mem_ctrl_end_inst (
    .clk(clk), .rst_b(rst_b), .link(snoop_link_if_inst),
    .reflect_en(reflect_en), .ack_src_en(ack_src_en),
    .min_rd_lat(min_rd_lat), .inv_delay(inv_delay),
    .rr_issue(rr_issue), .rr_resolve(rr_resolve),
    .rr_outstanding(rr_out), .aborted(aborted),
    .inv_fwd_valid(fwd_v), .inv_fwd_addr(fwd_a),
    .inv_fwd_ready(fwd_rdy));
  snoop_link_assertions snoop_link_assertions_inst (
    .clk(clk), .rst_b(rst_b),
    .address_strobe(snoop_link_if_inst.address_strobe),
    .txn_type(snoop_link_if_inst.txn_type),
    .intervention_inhibit(snoop_link_if_inst.intervention_inhibit),
    .shared_line_flag(snoop_link_if_inst.shared_line_flag),
    .data_ready_ack(snoop_link_if_inst.data_ready_ack),
    .relinquish_and_retry(snoop_link_if_inst.relinquish_and_retry));

  // ----------------------------------------
  // Monitor, timeout and helpers
  // ----------------------------------------
  // ack_at counts cycles from strobe to the first ack, 0 if none came
  always @(posedge clk) begin
    since <= snoop_link_if_inst.address_strobe ? 1 : since + 1;
    if (snoop_link_if_inst.address_strobe) ack_at <= 0;
    else if (snoop_link_if_inst.data_ready_ack && ack_at == 0)
      ack_at <= since;
    if (rdata_valid) rq.push_back(rdata);
    if (line_clean) g_clean <= 1'b1;
    if (aborted) g_abort <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk_w(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_b(input logic g, input logic e, input string m);
    chk_w({31'h0, g}, {31'h0, e}, m);
  endtask

  // Ends two edges after done or retried, so monitor results are settled
  task automatic run_cmd(input txn_t t, input logic [3:0] a,
                         input word_ofs_t o, input logic [31:0] w);
    int n;
    @(posedge clk);
    rq.delete();
    g_clean = 1'b0;
    g_abort = 1'b0;
    cmd_type <= t;
    cmd_addr <= a;
    cmd_offset <= o;
    cmd_wdata <= w;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && retried !== 1'b1 && n < 60);
    got_rt = (retried === 1'b1);
    chk_b(n < 60, 1'b1, "command completion");
    @(posedge clk);
    #1;
    @(posedge clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_wrap();
    for (int k = 0; k < 4; k++)
      run_cmd(k[0] ? TXN_COH_WRITE_INV : TXN_WRITE, 4'h3, word_ofs_t'(k),
              32'h000000a0 + 32'(k));
    run_cmd(TXN_COH_READ, 4'h3, 2'h2, 32'h0);
    chk_w(ack_at, 32'h4, "read latency");
    chk_w(rq.size(), 32'h4, "beats");
    for (int k = 0; k < 4; k++)
      chk_w(rq[k], 32'h000000a0 + 32'((k + 2) % 4), "wrap");
    $display("test wrap done");
  endtask

  task automatic t_lat();
    lat_t l[4] = '{4'hf, 4'h6, 4'h0, 4'h2};
    for (int i = 0; i < 4; i++) begin
      min_rd_lat <= l[i];
      run_cmd(i[0] ? TXN_COH_READ_INV : TXN_COH_READ, 4'h3, 2'h0, 32'h0);
      chk_w(ack_at, (l[i] < 2 ? 2 : l[i]) + 2, "min latency");
    end
    $display("test latency done");
  endtask

  task automatic t_inv();
    lat_t d[2] = '{4'h0, 4'h5};
    for (int i = 0; i < 2; i++) begin
      inv_delay <= d[i];
      run_cmd(TXN_COH_INV, 4'h2, 2'h0, 32'h0);
      chk_w(ack_at, (d[i] < 2 ? 2 : d[i]) + 1, "inv ack");
    end
    $display("test invalidate done");
  endtask

  task automatic t_reflect();
    reflect_en <= 1'b1;
    reflect_mode <= 1'b1;
    snoop_dirty <= 1'b1;
    snoop_shared <= 1'b1;
    run_cmd(TXN_COH_READ, 4'h5, 2'h1, 32'h0);
    #1;
    chk_b(saw_inh, 1'b1, "inhibit seen");
    chk_b(saw_sh, 1'b1, "shared seen");
    chk_b(g_clean, 1'b1, "line clean");
    chk_b(g_abort, 1'b0, "no abort");
    @(posedge clk);
    snoop_dirty <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      run_cmd(TXN_READ, 4'h5, word_ofs_t'(k), 32'h0);
      chk_w(rq[0], 32'hc0de0000 + 32'(k), "reflected");
    end
    $display("test reflect done");
  endtask

  task automatic t_abort();
    reflect_en <= 1'b0;
    reflect_mode <= 1'b0;
    run_cmd(TXN_WRITE, 4'h6, 2'h0, 32'h00000066);
    snoop_dirty <= 1'b1;
    run_cmd(TXN_COH_READ_INV, 4'h6, 2'h0, 32'h0);
    #1;
    chk_b(g_abort, 1'b1, "abort");
    chk_b(g_clean, 1'b0, "clean off");
    chk_b(fwd_v, 1'b1, "inv queued");
    chk_w({28'h0, fwd_a}, 32'h6, "inv addr");
    @(posedge clk);
    snoop_dirty <= 1'b0;
    fwd_rdy <= 1'b1;
    @(posedge clk);
    fwd_rdy <= 1'b0;
    run_cmd(TXN_READ, 4'h6, 2'h0, 32'h0);
    #1;
    chk_b(fwd_v, 1'b0, "inv drained");
    chk_w(rq[0], 32'h00000066, "memory kept");
    $display("test abort done");
  endtask

  task automatic t_retry();
    rr_issue <= 1'b1;
    run_cmd(TXN_COH_READ, 4'h9, 2'h0, 32'h0);
    rr_issue <= 1'b0;
    #1;
    chk_b(got_rt, 1'b1, "retried");
    chk_w(ack_at, 32'h0, "no ack");
    chk_b(rr_out, 1'b1, "owned");
    run_cmd(TXN_WRITE, 4'h9, 2'h0, 32'h0);
    chk_b(got_rt, 1'b1, "same line retried");
    rr_resolve <= 1'b1;
    @(posedge clk);
    rr_resolve <= 1'b0;
    run_cmd(TXN_COH_READ, 4'h9, 2'h0, 32'h0);
    #1;
    chk_b(got_rt, 1'b0, "resolved");
    chk_b(rr_out, 1'b0, "released");
    chk_w(ack_at, 32'h4, "acked");
    $display("test retry done");
  endtask

  // With memory not the ack source the cache waits; only reset frees it
  task automatic t_noack();
    @(posedge clk);
    ack_src_en <= 1'b0;
    cmd_type <= TXN_COH_INV;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk_w(ack_at, 32'h0, "no inv ack");
    chk_b(cmd_ready, 1'b0, "still waiting");
    @(posedge clk);
    rst_b <= 1'b0;
    ack_src_en <= 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    run_cmd(TXN_COH_INV, 4'h2, 2'h0, 32'h0);
    chk_w(ack_at, 32'h6, "ack after reset");
    $display("test ack disable done");
  endtask

  initial begin
    {rst_b, cmd_valid, snoop_dirty, snoop_shared, reflect_mode} = '0;
    {reflect_en, rr_issue, rr_resolve, fwd_rdy, got_rt} = '0;
    {g_clean, g_abort, cmd_addr, cmd_offset, cmd_wdata} = '0;
    {since, ack_at, cyc, error_cnt, num_checks} = '0;
    cmd_type = TXN_READ;
    ack_src_en = 1'b1;
    min_rd_lat = 4'h2;
    inv_delay = 4'h2;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_wrap();
    t_lat();
    t_inv();
    t_reflect();
    t_abort();
    t_retry();
    t_noack();
    stop_test();
  end
endmodule // test_coherent_snoop_response_timing

`default_nettype wire
